// ---- design/asc_pkg.sv ----
// Purpose: Shared constants and types for the static memory controller.
// Assumes: 25 MHz clock, 40 ns period.
// Notes: Times are in ns; cycle counts derive from them.
package asc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  // Memory timing figures
  localparam int unsigned T_READ_CYCLE_NS = 55;
  localparam int unsigned T_READ_ACCESS_NS = 55;
  localparam int unsigned T_OUT_FLOAT_NS = 20;
  localparam int unsigned T_LANE_FLOAT_NS = 25;
  localparam int unsigned T_WRITE_CYCLE_NS = 55;
  localparam int unsigned T_ADDR_TO_WRITE_END_NS = 50;
  localparam int unsigned T_WRITE_WIDTH_NS = 45;
  localparam int unsigned T_WRITE_TO_FLOAT_NS = 20;
  localparam int unsigned T_WRITE_DATA_SETUP_NS = 25;
  // Least times round up, at least one cycle
  function automatic int unsigned asc_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : asc_cyc_up
  // Read data is sampled after access time plus one spare cycle
  localparam int unsigned RD_CYC = asc_cyc_up(T_READ_ACCESS_NS) + 1;
  // Strobe low long enough for float delay plus data setup, and the strobe width
  localparam int unsigned WP_MIN_A = asc_cyc_up(T_WRITE_WIDTH_NS);
  localparam int unsigned WP_MIN_B = asc_cyc_up(T_WRITE_TO_FLOAT_NS + T_WRITE_DATA_SETUP_NS) + 1;
  localparam int unsigned WP_CYC = (WP_MIN_A > WP_MIN_B) ? WP_MIN_A : WP_MIN_B;
  // Turnaround after a read before anyone else drives
  localparam int unsigned TURN_CYC = asc_cyc_up(T_LANE_FLOAT_NS);
  // Recovery after retention exit, one read cycle time
  localparam int unsigned REC_CYC = asc_cyc_up(T_READ_CYCLE_NS);
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    ASC_IDLE = 3'b000,
    ASC_RD = 3'b001,
    ASC_WR = 3'b010,
    ASC_TURN = 3'b011,
    ASC_RET = 3'b100,
    ASC_REC = 3'b101
  } asc_state_t;

  // User request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_en;
  } asc_req_t;

  // Memory control pins, chip_select_n and the active-high select
  typedef struct packed {
    logic chip_select_n;
    logic chip_select_high_active;
    logic output_enable_n;
    logic write_strobe_n;
    logic low_lane_select_n;
    logic high_lane_select_n;
  } asc_ctl_t;

  localparam asc_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : asc_pkg

// ---- design/asc_timer.sv ----
// Purpose: Down counter that paces each phase of a memory access.
// Assumes: Loads win over counting.
// Notes: done is high while the count is zero.
`timescale 1ns/10ps
module asc_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic load,
  input wire logic [asc_pkg::CNT_W-1:0] value,
  // Status
  output logic done
);
  import asc_pkg::*;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // Next count
  assign cnt_next = load ? value : ((cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - 4'h1);
  assign done = (cnt_reg == CNT_ZERO);

  // Count register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : asc_timer

// ---- design/asc_ctrl.sv ----
// Purpose: Host-side controller driving an asynchronous 1M x 16 static memory.
// Assumes: Memory pins are driven from flops; data input is synchronous to clk.
// Notes: One access at a time; retention entry and exit on request.
//
// Overview of operation
// - Write strobe stays high throughout every read access.
// - Address changes only while no write can occur.
// - With output enable low, strobe exceeds float delay plus data setup.
// - Address is valid no later than select activation.
// - Address and selects held 50 ns before write end; cycle 55 ns.
// - Strobe low at least 45 ns; lane selects low 45 ns.
// - Write data valid 25 ns before write end; zero hold.
// - Controller never drives the bus while memory drives it.
// - Deselect before retention; wait one read cycle after recovery.
`timescale 1ns/10ps
module asc_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User request side
  input wire logic req_valid,
  input wire asc_pkg::asc_req_t req,
  output logic req_ready,
  output logic [asc_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Retention control
  input wire logic retain_req,
  output logic retained,
  // Memory pins
  output logic [asc_pkg::ADDR_W-1:0] address_lines,
  output asc_pkg::asc_ctl_t mem_ctl,
  input wire logic [asc_pkg::DATA_W-1:0] data_lines_in,
  output logic [asc_pkg::DATA_W-1:0] data_lines_out,
  output logic [asc_pkg::DATA_W-1:0] data_lines_oe
);
  import asc_pkg::*;

  asc_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg;
  asc_ctl_t ctl_reg, ctl_next;
  logic [DATA_W-1:0] dout_reg;
  logic [1:0] lane_reg;
  logic drive_reg, drive_next;
  logic [DATA_W-1:0] rdat_reg;
  logic rval_reg;
  logic ret_reg;
  logic t_load;
  logic [CNT_W-1:0] t_value;
  logic t_done;
  logic take;
  logic rd_capture;
  logic wr_end;

  // Phase timer
  asc_timer u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .load(t_load),
    .value(t_value),
    .done(t_done)
  );

  // Handshake decode
  assign req_ready = (state_reg == ASC_IDLE) && !retain_req;
  assign take = req_valid && req_ready && (req.lane_en != 2'b00);
  assign rd_capture = (state_reg == ASC_RD) && t_done;
  assign wr_end = (state_reg == ASC_WR) && t_done;

  // Next state and pin controls
  always_comb begin
    state_next = state_reg;
    ctl_next = ctl_reg;
    drive_next = drive_reg;
    t_load = 1'b0;
    t_value = CNT_ZERO;
    case (state_reg)
      ASC_IDLE: begin
        ctl_next = CTL_IDLE;
        drive_next = 1'b0;
        if (retain_req) begin
          state_next = ASC_RET;
        end else if (take) begin
          // Address goes out with the selects in the same edge
          ctl_next.chip_select_n = 1'b0;
          ctl_next.chip_select_high_active = 1'b1;
          ctl_next.low_lane_select_n = !req.lane_en[0];
          ctl_next.high_lane_select_n = !req.lane_en[1];
          t_load = 1'b1;
          if (req.write) begin
            ctl_next.write_strobe_n = 1'b0;
            drive_next = 1'b1;
            t_value = CNT_W'(WP_CYC - 1);
            state_next = ASC_WR;
          end else begin
            ctl_next.output_enable_n = 1'b0;
            t_value = CNT_W'(RD_CYC - 1);
            state_next = ASC_RD;
          end
        end
      end
      ASC_RD: begin
        if (t_done) begin
          ctl_next = CTL_IDLE;
          t_load = 1'b1;
          t_value = CNT_W'(TURN_CYC - 1);
          state_next = ASC_TURN;
        end
      end
      ASC_WR: begin
        if (t_done) begin
          // Strobe, selects and data released together, zero hold
          ctl_next = CTL_IDLE;
          drive_next = 1'b0;
          state_next = ASC_IDLE;
        end
      end
      ASC_TURN: begin
        if (t_done) begin
          state_next = ASC_IDLE;
        end
      end
      ASC_RET: begin
        ctl_next = CTL_IDLE;
        if (!retain_req) begin
          t_load = 1'b1;
          t_value = CNT_W'(REC_CYC - 1);
          state_next = ASC_REC;
        end
      end
      ASC_REC: begin
        if (t_done) begin
          state_next = ASC_IDLE;
        end
      end
      default: begin
        state_next = ASC_IDLE;
        ctl_next = CTL_IDLE;
        drive_next = 1'b0;
      end
    endcase
  end

  // State and pin registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ASC_IDLE;
      ctl_reg <= CTL_IDLE;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctl_reg <= ctl_next;
      drive_reg <= drive_next;
    end
  end

  // Address, data and lane registers only load on a taken request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= '0;
      dout_reg <= '0;
      lane_reg <= 2'b00;
    end else if (take) begin
      addr_reg <= req.addr;
      dout_reg <= req.wdata;
      lane_reg <= req.lane_en;
    end
  end

  // Read capture, disabled lanes read as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdat_reg <= '0;
      rval_reg <= 1'b0;
    end else begin
      rval_reg <= rd_capture;
      if (rd_capture) begin
        rdat_reg <= data_lines_in & {{8{lane_reg[1]}}, {8{lane_reg[0]}}};
      end
    end
  end

  // Retention status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ret_reg <= 1'b0;
    end else begin
      ret_reg <= (state_next == ASC_RET);
    end
  end

  // Outputs
  assign address_lines = addr_reg;
  assign mem_ctl = ctl_reg;
  assign data_lines_out = dout_reg;
  assign data_lines_oe = {{8{drive_reg & lane_reg[1]}}, {8{drive_reg & lane_reg[0]}}};
  assign rd_data = rdat_reg;
  assign rd_valid = rval_reg;
  assign retained = ret_reg;

  // Checks
  logic wr_active;
  assign wr_active = !ctl_reg.write_strobe_n;

  AST_RD_STROBE_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
    !ctl_reg.output_enable_n |-> ctl_reg.write_strobe_n)
    else $error("strobe low during read");
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(addr_reg) |-> $past(ctl_reg.write_strobe_n))
    else $error("address changed during write");
  AST_WP_WIDTH: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(ctl_reg.write_strobe_n) |-> !ctl_reg.write_strobe_n [*2])
    else $error("write strobe too short");
  AST_WR_DATA: assert property (@(posedge clk) disable iff (!arst_n)
    wr_active |-> drive_reg && !ctl_reg.chip_select_n)
    else $error("write data not driven");
  AST_NO_CLASH: assert property (@(posedge clk) disable iff (!arst_n)
    drive_reg |-> ctl_reg.output_enable_n)
    else $error("bus driven with output enable low");
  AST_TURN: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ctl_reg.output_enable_n) |-> !drive_reg [*2])
    else $error("drive right after read");
  AST_RD_TIME: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(ctl_reg.output_enable_n) |-> ##2 rd_capture)
    else $error("read sampled at wrong time");
  AST_RET_DESEL: assert property (@(posedge clk) disable iff (!arst_n)
    retained |-> ctl_reg.chip_select_n && !ctl_reg.chip_select_high_active)
    else $error("selected in retention");
  AST_LANE: assert property (@(posedge clk) disable iff (!arst_n)
    wr_active |-> (data_lines_oe[0] == !ctl_reg.low_lane_select_n))
    else $error("lane drive mismatch");

  COV_READ: cover property (@(posedge clk) disable iff (!arst_n) rval_reg);
  COV_WRITE: cover property (@(posedge clk) disable iff (!arst_n) wr_end);
  COV_RET: cover property (@(posedge clk) disable iff (!arst_n) $fell(retained));
endmodule : asc_ctrl

// ---- testbench/asc_mem_model.sv ----
// Purpose: Behavioural 1M x 16 static memory facing the controller.
// Assumes: Pins change on clk edges; reads answer at once.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/10ps
module asc_mem_model (
  // Clock
  input wire logic clk,
  // Memory pins
  input wire logic [asc_pkg::ADDR_W-1:0] address_lines,
  input wire asc_pkg::asc_ctl_t mem_ctl,
  input wire logic [asc_pkg::DATA_W-1:0] data_lines_out,
  input wire logic [asc_pkg::DATA_W-1:0] data_lines_oe,
  output logic [asc_pkg::DATA_W-1:0] data_lines_in,
  // Protocol slips seen
  output logic [7:0] errs
);
  import asc_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] word, last, drv;
  logic [ADDR_W-1:0] prev_addr;
  logic prev_wr;
  // Decode of selects and strobe
  wire sel = ~mem_ctl.chip_select_n & mem_ctl.chip_select_high_active;
  wire lo = ~mem_ctl.low_lane_select_n;
  wire hi = ~mem_ctl.high_lane_select_n;
  wire wr = sel & ~mem_ctl.write_strobe_n & (lo | hi);
  wire rd = sel & ~mem_ctl.output_enable_n & mem_ctl.write_strobe_n;
  assign drv = {{8{rd & hi}}, {8{rd & lo}}};
  assign word = mem[address_lines];
  // Driven lanes carry the word, others float as a changing pattern
  assign data_lines_in = (drv & word) | (~drv & ~last);
  initial begin
    errs = 8'h00;
    last = 16'h0000;
    prev_wr = 1'b0;
    prev_addr = 20'h0_0000;
  end
  // Store enabled lanes, watch the controller's own duties
  always @(posedge clk) begin
    last <= data_lines_in;
    prev_wr <= wr;
    prev_addr <= address_lines;
    if (wr) begin
      mem[address_lines] = (word & ~{{8{hi}}, {8{lo}}}) | (data_lines_out & {{8{hi}}, {8{lo}}});
    end
    if (prev_wr && address_lines != prev_addr) begin
      errs <= errs + 8'h01;
    end
    if ((data_lines_oe & drv) != 16'h0000) begin
      errs <= errs + 8'h01;
    end
  end
endmodule : asc_mem_model

// ---- testbench/async_sram_16bit_bus_timing_tb.sv ----
// Purpose: Self-checking bench for the static memory controller.
// Assumes: Inputs change on falling edges.
// Notes: Each scenario task judges its own results.
`timescale 1ns/10ps
module async_sram_16bit_bus_timing_tb;
  import asc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  asc_req_t req = '0;
  logic retain_req = 1'b0;
  logic req_ready, rd_valid, retained;
  logic [DATA_W-1:0] rd_data, dq_in, dq_out, dq_oe;
  logic [ADDR_W-1:0] addr;
  asc_ctl_t mem_ctl;
  logic [7:0] errs;
  int n_fail = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  asc_ctrl i_asc_ctrl (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .retain_req(retain_req),
    .retained(retained), .address_lines(addr), .mem_ctl(mem_ctl), .data_lines_in(dq_in),
    .data_lines_out(dq_out), .data_lines_oe(dq_oe));
  asc_mem_model i_asc_mem_model (.clk(clk), .address_lines(addr), .mem_ctl(mem_ctl),
    .data_lines_out(dq_out), .data_lines_oe(dq_oe), .data_lines_in(dq_in), .errs(errs));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Issue one request; returns cycles to ready, strobe-low cycles and read data
  task automatic xfer(input logic w, input logic [19:0] a, input logic [15:0] d,
    input logic [1:0] ln, output int k, output int wl, output int rv, output logic [15:0] q);
    k = 0;
    wl = 0;
    rv = -1;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{w, a, d, ln};
    @(negedge clk);
    req_valid = 1'b0;
    while (req_ready !== 1'b1 && k < 20) begin
      if (mem_ctl.write_strobe_n === 1'b0) begin
        wl++;
        chk("wr_oe", {{8{ln[1]}}, {8{ln[0]}}}, dq_oe);
      end
      if (rd_valid === 1'b1) begin
        rv = k;
        q = rd_data;
      end
      @(negedge clk);
      k++;
    end
  endtask : xfer
  task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln);
    int k, wl, rv;
    logic [15:0] q;
    xfer(1'b1, a, d, ln, k, wl, rv, q);
    chk("wr_ready", 3, k);
    chk("wr_width", WP_CYC, wl);
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [1:0] ln, input logic [15:0] e);
    int k, wl, rv;
    logic [15:0] q;
    xfer(1'b0, a, 16'h0000, ln, k, wl, rv, q);
    chk("rd_strobe", 0, wl);
    chk("rd_lat", RD_CYC, rv);
    chk("rd_data", e, q);
    chk("rd_ready", RD_CYC + TURN_CYC, k);
  endtask : rd
  task automatic t_lanes();
    wr(20'h0_0010, 16'hA5C3, 2'b11);
    rd(20'h0_0010, 2'b11, 16'hA5C3);
    wr(20'hF_FFFF, 16'h1111, 2'b01);
    wr(20'hF_FFFF, 16'h2222, 2'b10);
    wr(20'h0_0010, 16'h7E00, 2'b10);
    rd(20'hF_FFFF, 2'b11, 16'h2211);
    rd(20'h0_0010, 2'b01, 16'h00C3);
    rd(20'h0_0010, 2'b10, 16'h7E00);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_nolane();
    @(negedge clk);
    req_valid = 1'b1;
    req = '{1'b1, 20'h0_0010, 16'hFFFF, 2'b00};
    repeat (3) begin
      @(negedge clk);
      chk("nolane_ctl", CTL_IDLE, mem_ctl);
    end
    req_valid = 1'b0;
    $display("test nolane done");
  endtask : t_nolane
  task automatic t_retain();
    int k;
    k = 0;
    @(negedge clk);
    retain_req = 1'b1;
    @(negedge clk);
    chk("ret_flag", 1, retained);
    chk("ret_cs", 1, mem_ctl.chip_select_n);
    chk("ret_ready", 0, req_ready);
    retain_req = 1'b0;
    while (req_ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("ret_rec", 1, k >= REC_CYC);
    chk("ret_clear", 0, retained);
    rd(20'h0_0010, 2'b11, 16'h7EC3);
    $display("test retain done");
  endtask : t_retain
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog well beyond the expected sixty-odd cycles
  initial begin
    #80000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk("rst_ctl", CTL_IDLE, mem_ctl);
    chk("rst_oe", 0, dq_oe);
    t_lanes();
    t_nolane();
    t_retain();
    chk("mem_errs", 0, errs);
    complete_run();
  end
endmodule : async_sram_16bit_bus_timing_tb
